/* rtl/eisc_pkg.sv */
// package of constants, types and helpers for the external interrupt sensitivity block
`default_nettype none
package eisc_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NPORT = 6; // ports A..F
  localparam int NPIN_PORT = 8; // pins 0..7 per port
  localparam int NPIN = NPORT * NPIN_PORT;
  localparam int NLINE = 4; // external lines zero..three
  localparam int PRIO_W = 2; // levels 0..3
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int LINE_ZERO = 0;
  localparam int LINE_ONE = 1;
  localparam int LINE_TWO = 2;
  localparam int LINE_THREE = 3;
  localparam logic [2:0] PORT_LAST_OK = 3'h5; // highest valid port index
  localparam logic [2:0] PORT_DIS_LAST = 3'h2; // disable only reaches ports A..C
  localparam logic [PRIO_W-1:0] LEVEL_TOP = 2'h3;
  localparam logic [PRIO_W-1:0] LEVEL_ZERO = 2'h0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h3;
  // ------------------------------------------------------------
  // sensitivity choices
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    sense_fall_low,
    sense_rise_only,
    sense_fall_only,
    sense_both_edges,
    sense_rise_high,
    sense_fixed_default
  } eisc_sense_e;
  // what a pin left at its default actually detects
  localparam eisc_sense_e FIXED_SENSE = sense_fall_low;
  // swap used by the revert request on lines zero and two
  function automatic eisc_sense_e eisc_revert(input eisc_sense_e s);
    case (s)
      sense_fall_low: eisc_revert = sense_rise_high;
      sense_rise_high: eisc_revert = sense_fall_low;
      sense_rise_only: eisc_revert = sense_fall_only;
      sense_fall_only: eisc_revert = sense_rise_only;
      default: eisc_revert = s;
    endcase
  endfunction
  // line that a pin feeds; port C follows the option setting
  function automatic int eisc_line_of(input int pin, input logic opt);
    int port;
    port = pin / NPIN_PORT;
    if (port == PORT_A) eisc_line_of = LINE_ZERO;
    else if (port == PORT_B) eisc_line_of = LINE_ONE;
    else if (port == PORT_C) eisc_line_of = opt ? LINE_ONE : LINE_ZERO;
    else if (port == PORT_D) eisc_line_of = LINE_TWO;
    else eisc_line_of = LINE_THREE;
  endfunction
endpackage
`default_nettype wire

/* rtl/eisc_det_if.sv */
// interface carrying one pin's configuration to its detector and its hits back
`default_nettype none
interface eisc_det_if;
  import eisc_pkg::*;
  logic en; // pin interrupt enabled
  eisc_sense_e sense; // selected sensitivity
  logic edge_hit; // one-cycle edge event
  logic level_hit; // active level present
  logic low_mask; // enabled edge pin held low
  modport top (output en, output sense, input edge_hit, input level_hit, input low_mask);
  modport det (input en, input sense, output edge_hit, output level_hit, output low_mask);
endinterface
`default_nettype wire

/* rtl/eisc_pin_det.sv */
// per-pin synchroniser and edge/level detector
`default_nettype none
module eisc_pin_det
  import eisc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // raw pin and carrier
  input wire logic pin_raw,
  eisc_det_if.det di
);
  logic s1_r; // first sync stage, read only by s2_r
  logic s2_r; // synchronised level
  logic s3_r; // previous synchronised level
  logic edge_r; // registered edge event
  eisc_sense_e eff; // sensitivity in force
  logic rise;
  logic fall;
  // ------------------------------------------------------------
  // synchroniser
  // ------------------------------------------------------------
  // two stages because the pin is asynchronous to clk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // ------------------------------------------------------------
  // detection
  // ------------------------------------------------------------
  // default sensitivity resolves to the fixed choice
  always_comb
  begin
    eff = (di.sense == sense_fixed_default) ? FIXED_SENSE : di.sense;
    rise = s2_r & ~s3_r;
    fall = ~s2_r & s3_r;
  end
  // edge event, registered so the carrier sees a clean pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      edge_r <= 1'b0;
    else
    begin
      case (eff)
        sense_fall_low, sense_fall_only: edge_r <= di.en & fall;
        sense_rise_only, sense_rise_high: edge_r <= di.en & rise;
        sense_both_edges: edge_r <= di.en & (rise | fall);
        default: edge_r <= 1'b0;
      endcase
    end
  end
  assign di.edge_hit = edge_r;
  // level requests follow the synchronised pin
  assign di.level_hit = di.en & (((eff == sense_fall_low) & ~s2_r) |
                                 ((eff == sense_rise_high) & s2_r));
  // low level on an edge-only pin masks its line
  assign di.low_mask = di.en & ~s2_r & (eff != sense_fall_low) & (eff != sense_rise_high);
endmodule
`default_nettype wire

/* rtl/eisc_top.sv */
// external interrupt configuration, sensitivity and line combining logic
//
// Contract
// - software trap is non-maskable, even at level three
// - configure write enables pin and sets sensitivity
// - five selectable sensitivities per pin
// - fixed pins keep default sensitivity always
// - unsupported sensitivity leaves setting unchanged
// - line masked while enabled edge-only pin held low
// - pins sharing a line are ORed
// - pins on ports A to C can be disabled
// - disable of non-interrupt pin changes nothing
// - revert swaps sensitivities on lines zero, two
// - option routes port C to line zero/one
// - readable priority per line and current level
`default_nettype none
module eisc_top
  import eisc_pkg::*;
#(
  parameter logic [eisc_pkg::NPIN-1:0] FIXED_MASK = '0, // pins with fixed sensitivity
  parameter logic [eisc_pkg::NPIN-1:0] LEVEL_OK_MASK = '1, // pins allowing level modes
  parameter logic [eisc_pkg::NPIN-1:0] IRQ_PIN_MASK = '1 // pins that are interrupt pins
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins and option
  input wire logic [eisc_pkg::NPIN-1:0] pin_in,
  input wire logic portc_line_select_option,
  // configure request
  input wire logic cfg_we,
  input wire logic [2:0] cfg_port,
  input wire logic [2:0] cfg_pin,
  input wire eisc_pkg::eisc_sense_e cfg_sense,
  // disable request
  input wire logic dis_we,
  input wire logic [2:0] dis_port,
  input wire logic [2:0] dis_pin,
  // revert request: 0 selects line zero, 1 line two
  input wire logic rev_we,
  input wire logic rev_sel,
  // priority write
  input wire logic prio_we,
  input wire logic [1:0] prio_line,
  input wire logic [eisc_pkg::PRIO_W-1:0] prio_val,
  // core side
  input wire logic ack_valid,
  input wire logic [1:0] ack_line,
  input wire logic iret,
  input wire logic trap_req,
  input wire logic trap_ack,
  output logic [eisc_pkg::NLINE-1:0] irq_line,
  output logic trap_nmi,
  output logic [eisc_pkg::NLINE-1:0][eisc_pkg::PRIO_W-1:0] prio_out,
  output logic [eisc_pkg::PRIO_W-1:0] cur_level,
  output logic [eisc_pkg::NPIN-1:0] alt_func_ok
);
  logic [NPIN-1:0] en_r; // pin interrupt enables
  eisc_sense_e sense_r [NPIN]; // pin sensitivities
  logic [NLINE-1:0][PRIO_W-1:0] prio_r; // line priorities
  logic [PRIO_W-1:0] cur_level_r; // level being serviced
  logic [NLINE-1:0] pend_r; // held edge requests
  logic trap_r; // pending trap
  logic opt_r; // captured option
  logic opt_done_r; // option captured once
  logic [NPIN-1:0] edge_vec, lvl_vec, low_vec;
  logic [NLINE-1:0] line_edge, line_lvl, line_low;
  logic [NPIN-1:0] member [NLINE]; // pin-to-line map
  logic [5:0] cfg_idx, dis_idx;
  logic cfg_ok, dis_ok, cfg_sup;
  assign cfg_idx = {cfg_port, cfg_pin};
  assign dis_idx = {dis_port, dis_pin};
  assign cfg_ok = cfg_we & (cfg_port <= PORT_LAST_OK);
  assign dis_ok = dis_we & (dis_port <= PORT_DIS_LAST) & IRQ_PIN_MASK[dis_idx];
  // level modes only where the pin offers them
  assign cfg_sup = LEVEL_OK_MASK[cfg_idx] |
                   ((cfg_sense != sense_fall_low) & (cfg_sense != sense_rise_high));
  // ------------------------------------------------------------
  // per-pin detectors
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      eisc_det_if di ();
      assign di.en = en_r[g];
      assign di.sense = sense_r[g];
      assign edge_vec[g] = di.edge_hit;
      assign lvl_vec[g] = di.level_hit;
      assign low_vec[g] = di.low_mask;
      eisc_pin_det u_det (
        .clk(clk),
        .resetn(resetn),
        .pin_raw(pin_in[g]),
        .di(di)
      );
    end
  endgenerate
  // ------------------------------------------------------------
  // line combining
  // ------------------------------------------------------------
  // membership follows the captured option for port C
  always_comb
  begin
    for (int l = 0; l < NLINE; l++)
    begin
      for (int p = 0; p < NPIN; p++)
        member[l][p] = (eisc_line_of(p, opt_r) == l);
      line_edge[l] = |(edge_vec & member[l]);
      line_lvl[l] = |(lvl_vec & member[l]);
      line_low[l] = |(low_vec & member[l]);
    end
  end
  // ------------------------------------------------------------
  // option capture
  // ------------------------------------------------------------
  // the option is static, caught once after reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      opt_r <= 1'b0;
      opt_done_r <= 1'b0;
    end
    else if (!opt_done_r)
    begin
      opt_r <= portc_line_select_option;
      opt_done_r <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // pin configuration
  // ------------------------------------------------------------
  // configure beats disable beats revert in one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_r <= '0;
      for (int p = 0; p < NPIN; p++)
        sense_r[p] <= sense_fixed_default;
    end
    else if (cfg_ok)
    begin
      en_r[cfg_idx] <= 1'b1;
      if (FIXED_MASK[cfg_idx])
        sense_r[cfg_idx] <= sense_fixed_default;
      else if (cfg_sup)
        sense_r[cfg_idx] <= cfg_sense;
      // unsupported choice: sense kept as it was
    end
    else if (dis_ok)
      en_r[dis_idx] <= 1'b0;
    else if (rev_we)
    begin
      // fixed pins cannot be reverted
      for (int p = 0; p < NPIN; p++)
        if (member[rev_sel ? LINE_TWO : LINE_ZERO][p] && !FIXED_MASK[p])
          sense_r[p] <= eisc_revert(sense_r[p]);
    end
  end
  assign alt_func_ok = ~en_r;
  // ------------------------------------------------------------
  // pending, priority and trap
  // ------------------------------------------------------------
  // a new edge wins over a same-cycle acknowledge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pend_r <= '0;
    else
      for (int l = 0; l < NLINE; l++)
        pend_r[l] <= line_edge[l] |
                     (pend_r[l] & ~(ack_valid & (ack_line == l[1:0])));
  end
  // priorities and the level now in service
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prio_r <= {NLINE{PRIO_RESET}};
      cur_level_r <= LEVEL_ZERO;
    end
    else
    begin
      if (prio_we)
        prio_r[prio_line] <= prio_val;
      if (ack_valid)
        cur_level_r <= prio_r[ack_line];
      else if (iret)
        cur_level_r <= LEVEL_ZERO;
    end
  end
  // trap request held until the core takes it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      trap_r <= 1'b0;
    else
      trap_r <= trap_req | (trap_r & ~trap_ack);
  end
  assign trap_nmi = trap_r;
  assign prio_out = prio_r;
  assign cur_level = cur_level_r;
  // lines are blocked at the top level and by a held-low edge-only pin
  assign irq_line = (pend_r | line_lvl) & ~line_low &
                    {NLINE{cur_level_r != LEVEL_TOP}};
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_TRAP_NMI: assert property (trap_req && cur_level_r == LEVEL_TOP |=> trap_nmi)
    else $error("trap not taken at top level");
  AST_CFG_EN: assert property (cfg_ok |=> en_r[$past(cfg_idx)])
    else $error("configure did not enable pin");
  AST_CFG_SENSE: assert property (cfg_ok && cfg_sup && !FIXED_MASK[cfg_idx]
    |=> sense_r[$past(cfg_idx)] == $past(cfg_sense))
    else $error("sensitivity not stored");
  AST_FIXED: assert property (cfg_ok && FIXED_MASK[cfg_idx]
    |=> sense_r[$past(cfg_idx)] == sense_fixed_default)
    else $error("fixed pin sensitivity changed");
  AST_UNSUP: assert property (cfg_ok && !cfg_sup
    |=> sense_r[$past(cfg_idx)] == $past(sense_r[cfg_idx]))
    else $error("unsupported sensitivity applied");
  AST_MASK: assert property (line_low[0] |-> !irq_line[0])
    else $error("line zero not masked by low pin");
  AST_OR: assert property (line_edge[1] |=> pend_r[1])
    else $error("shared line request lost");
  // alt function follows the cleared enable in the same cycle; a later
  // configure may re-enable the pin, so only the next cycle is checked
  AST_DIS: assert property (dis_ok && !cfg_ok
    |=> !en_r[$past(dis_idx)] && alt_func_ok[$past(dis_idx)])
    else $error("pin not disabled");
  AST_DIS_BAD: assert property (dis_we && !dis_ok && !cfg_ok && !rev_we
    |=> $stable(en_r))
    else $error("bad disable changed enables");
  AST_REV: assert property (rev_we && !cfg_ok && !dis_ok && !rev_sel
    && !FIXED_MASK[0] && sense_r[0] == sense_fall_only |=> sense_r[0] == sense_rise_only)
    else $error("revert did not swap");
  AST_OPT: assert property (opt_done_r |-> member[LINE_ONE][PORT_C*NPIN_PORT] == opt_r)
    else $error("port c routed wrong");
  AST_LEVEL: assert property (ack_valid |=> cur_level == $past(prio_r[ack_line]))
    else $error("current level not the acked priority");
  AST_PEND: assert property (pend_r[2] && !(ack_valid && ack_line == 2'h2)
    |=> pend_r[2])
    else $error("pending edge dropped");
  COV_TRAP: cover property (trap_req && cur_level_r == LEVEL_TOP ##1 trap_nmi);
  COV_EDGE: cover property (line_edge[0] ##1 irq_line[0] ##[1:8] ack_valid);
  COV_REV: cover property (rev_we && rev_sel);
  COV_DIS: cover property (dis_ok);
endmodule
`default_nettype wire

/* tb/eisc_pin_model.sv */
// behavioural model of the port pads that feed the external interrupt pins
`default_nettype none
module eisc_pin_model
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level change command from the bench
  input wire logic set_we,
  input wire logic [5:0] set_idx,
  input wire logic set_val,
  // pad levels seen by the block
  output logic [eisc_pkg::NPIN-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // pads idle high through pull-ups, already in input-interrupt mode
  // a change lands one edge after the command, never mid-cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pins <= '1;
    else if (set_we)
      pins[set_idx] <= set_val;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the external interrupt sensitivity block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eisc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'h0, resetn = 1'h0, opt = 1'h0, set_we = 1'h0, set_val = 1'h1;
  logic cfg_we = 1'h0, dis_we = 1'h0, rev_we = 1'h0, rev_sel = 1'h0, prio_we = 1'h0;
  logic ack_valid = 1'h0, iret = 1'h0, trap_req = 1'h0, trap_ack = 1'h0, trap_nmi;
  logic [2:0] cfg_port = 3'h0, cfg_pin = 3'h0, dis_port = 3'h0, dis_pin = 3'h0;
  logic [1:0] prio_line = 2'h0, prio_val = 2'h0, ack_line = 2'h0;
  logic [5:0] set_idx = 6'h0;
  eisc_sense_e cfg_sense = sense_rise_only;
  logic [NPIN-1:0] pin_in, alt_func_ok;
  logic [NLINE-1:0] irq_line;
  logic [NLINE-1:0][PRIO_W-1:0] prio_out;
  logic [PRIO_W-1:0] cur_level;
  int failures = 0, cmp_count = 0, idx;
  // one case: pin, option, sense, levels before and after, lines expected
  typedef struct {logic [2:0] port; logic [2:0] pin; logic opt; eisc_sense_e sense;
    logic pre; logic post; logic [3:0] exp;} eisc_row_s;
  eisc_row_s rows [10] = '{
    '{3'h0, 3'h0, 1'h0, sense_rise_only, 1'h0, 1'h1, 4'h1},
    '{3'h1, 3'h3, 1'h0, sense_both_edges, 1'h0, 1'h1, 4'h2},
    '{3'h2, 3'h5, 1'h0, sense_rise_only, 1'h0, 1'h1, 4'h1},
    '{3'h2, 3'h5, 1'h1, sense_rise_only, 1'h0, 1'h1, 4'h2},
    '{3'h3, 3'h7, 1'h0, sense_rise_high, 1'h0, 1'h1, 4'h4},
    '{3'h4, 3'h2, 1'h0, sense_fall_low, 1'h1, 1'h0, 4'h8},
    '{3'h5, 3'h1, 1'h0, sense_fall_only, 1'h1, 1'h0, 4'h0}, // masked while low
    '{3'h1, 3'h1, 1'h0, sense_rise_only, 1'h1, 1'h0, 4'h2}, // fixed pin
    '{3'h3, 3'h2, 1'h0, sense_rise_high, 1'h1, 1'h0, 4'h4}, // no level modes here
    '{3'h6, 3'h0, 1'h0, sense_rise_only, 1'h0, 1'h1, 4'h0}}; // no such port
  // ------------------------------------------------------------
  // clock, design and pad model
  // ------------------------------------------------------------
  initial
  begin
    forever #10 clk = ~clk;
  end
  // pin 9 fixed, pin 26 without level modes, pin 4 not an interrupt pin
  eisc_top #(.FIXED_MASK(48'h0000_0000_0200), .LEVEL_OK_MASK(48'hFFFF_FBFF_FFFF),
    .IRQ_PIN_MASK(48'hFFFF_FFFF_FFEF)) dut (.clk(clk), .resetn(resetn), .pin_in(pin_in),
    .portc_line_select_option(opt), .cfg_we(cfg_we), .cfg_port(cfg_port),
    .cfg_pin(cfg_pin), .cfg_sense(cfg_sense), .dis_we(dis_we), .dis_port(dis_port),
    .dis_pin(dis_pin), .rev_we(rev_we), .rev_sel(rev_sel), .prio_we(prio_we),
    .prio_line(prio_line), .prio_val(prio_val), .ack_valid(ack_valid),
    .ack_line(ack_line), .iret(iret), .trap_req(trap_req), .trap_ack(trap_ack),
    .irq_line(irq_line), .trap_nmi(trap_nmi), .prio_out(prio_out),
    .cur_level(cur_level), .alt_func_ok(alt_func_ok));
  eisc_pin_model pads (.clk(clk), .resetn(resetn), .set_we(set_we), .set_idx(set_idx),
    .set_val(set_val), .pins(pin_in));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // wait n edges, then a little more so design updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // compare and count; a mismatch is reported at once
  task automatic chk(input string what, input logic [NPIN-1:0] seen,
    input logic [NPIN-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reset held 4 cycles; option is stable before release so it is captured
  task automatic do_reset(input logic o);
    @(posedge clk);
    resetn <= 1'h0;
    opt <= o;
    tick(4);
    resetn <= 1'h1;
    tick(2);
  endtask
  // one-cycle request: 0 cfg, 1 disable, 2 revert, 3 prio, 4 ack, 5 iret, 6/7 trap
  task automatic req(input int k, input logic [2:0] a, input logic [2:0] b = 3'h0,
    input eisc_sense_e s = sense_rise_only);
    @(posedge clk);
    case (k)
      0:
      begin
        // enum kept out of the concatenation so no plain bits land in it
        {cfg_we, cfg_port, cfg_pin} <= {1'h1, a, b};
        cfg_sense <= s;
      end
      1: {dis_we, dis_port, dis_pin} <= {1'h1, a, b};
      2: {rev_we, rev_sel} <= {1'h1, a[0]};
      3: {prio_we, prio_line, prio_val} <= {1'h1, a[1:0], b[1:0]};
      4: {ack_valid, ack_line} <= {1'h1, a[1:0]};
      5: iret <= 1'h1;
      6: trap_req <= 1'h1;
      default: trap_ack <= 1'h1;
    endcase
    @(posedge clk);
    {cfg_we, dis_we, rev_we, prio_we, ack_valid, iret, trap_req, trap_ack} <= 8'h00;
  endtask
  // ask the pad model for a new level on one pin
  task automatic pinset(input int i, input logic v);
    @(posedge clk);
    {set_we, set_idx, set_val} <= {1'h1, 6'(i), v};
    @(posedge clk);
    set_we <= 1'h0;
  endtask
  // hang guard: running out counts as a mismatch
  initial
  begin
    tick(20000);
    failures++;
    end_sim();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset(1'h0);
    chk("irq_line", irq_line, 48'h0);
    chk("trap_nmi", trap_nmi, 48'h0);
    chk("prio_out", prio_out, 48'hFF);
    chk("cur_level", cur_level, 48'h0);
    chk("alt_func_ok", alt_func_ok, '1);
    // table of pin cases, each from a fresh reset
    foreach (rows[i])
    begin
      do_reset(rows[i].opt);
      idx = (rows[i].port > 3'h5) ? int'(rows[i].pin) : int'(rows[i].port) * 8 + rows[i].pin;
      pinset(idx, rows[i].pre);
      tick(4);
      req(0, rows[i].port, rows[i].pin, rows[i].sense);
      tick(2);
      chk("alt_func_ok", alt_func_ok[idx], rows[i].port > 3'h5);
      pinset(idx, rows[i].post);
      tick(8);
      chk("irq_line", irq_line, rows[i].exp);
    end
    // disable: allowed pin, port beyond C, non-interrupt pin
    do_reset(1'h0);
    req(0, 3'h0, 3'h0);
    req(0, 3'h3, 3'h0);
    req(0, 3'h0, 3'h4);
    req(1, 3'h0, 3'h0);
    req(1, 3'h3, 3'h0);
    req(1, 3'h0, 3'h4);
    tick(2);
    chk("alt_func_ok a0", alt_func_ok[0], 48'h1);
    chk("alt_func_ok d0", alt_func_ok[24], 48'h0);
    chk("alt_func_ok a4", alt_func_ok[4], 48'h0);
    // revert on line zero twice, then on line two; pins stay high
    do_reset(1'h0);
    req(0, 3'h0, 3'h0, sense_fall_low);
    req(0, 3'h3, 3'h0, sense_fall_low);
    tick(4);
    chk("irq_line", irq_line, 48'h0);
    req(2, 3'h0);
    tick(4);
    chk("irq_line", irq_line, 48'h1);
    req(2, 3'h0);
    req(2, 3'h1);
    tick(4);
    chk("irq_line", irq_line, 48'h4);
    // fall-only reverted to rise-only: a fall sets nothing, the rise does
    req(0, 3'h0, 3'h0, sense_fall_only);
    req(2, 3'h0);
    pinset(0, 1'h0);
    tick(6);
    // clear any pending left by the fall, then leave the top level again
    req(4, 3'h0);
    req(5, 3'h0);
    pinset(0, 1'h1);
    tick(8);
    chk("irq_line", irq_line, 48'h5);
    // priority for line zero, then two pins on it, edge on one; then ack and return
    do_reset(1'h0);
    req(3, 3'h0, 3'h2);
    tick(1);
    chk("prio_out", prio_out[0], 48'h2);
    pinset(1, 1'h0);
    req(0, 3'h0, 3'h0);
    req(0, 3'h0, 3'h1);
    pinset(1, 1'h1);
    tick(8);
    chk("irq_line", irq_line, 48'h1);
    req(4, 3'h0);
    tick(2);
    chk("cur_level", cur_level, 48'h2);
    chk("irq_line", irq_line, 48'h0);
    req(5, 3'h0);
    tick(2);
    chk("cur_level", cur_level, 48'h0);
    // trap is still taken at the top level
    req(3, 3'h0, 3'h3);
    req(4, 3'h0);
    tick(2);
    chk("cur_level", cur_level, 48'h3);
    req(6, 3'h0);
    tick(2);
    chk("trap_nmi", trap_nmi, 48'h1);
    req(7, 3'h0);
    tick(2);
    chk("trap_nmi", trap_nmi, 48'h0);
    end_sim();
  end
endmodule
`default_nettype wire
